// ==== srci_crc8.sv ====
// Bitwise CRC-8 step, polynomial x^8+x^2+x+1, MSB first.
// Purely combinational; caller holds the register.
module srci_crc8
  import srci_pkg::*;
(
  input wire logic [7:0] crc_in,
  input wire logic bit_in,
  output logic [7:0] crc_out
);
  // Shift left, fold in the generator when the top bit differs
  always_comb begin
    crc_out = {crc_in[6:0], 1'b0} ^ ((crc_in[7] ^ bit_in) ? CRC_POLY : 8'h00);
  end
endmodule // srci_crc8

// ==== srci_host_model.sv ====
// Host controller model for the serial responder: mode 0 frames.
// Assumes the bench calls frame() or stall() and spaces frames apart.
module srci_host_model (
  input wire logic clk,
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 1ps;
  bit busy = 1'b0;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // Idle data pin toggles so a leftover bit is never mistaken for data
  always @(posedge clk) begin
    if (!busy) mosi <= ~mosi;
  end
  // Clock idles low, data changes after a fall and is read at a rise
  task automatic frame(input int nb, input int hp, input logic [23:0] din,
                       output logic [23:0] dout);
    dout = '0;
    busy = 1'b1;
    @(posedge clk);
    cs_n <= 1'b0;
    mosi <= din[nb-1];
    repeat (hp) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      sclk <= 1'b1;
      dout = {dout[22:0], miso};
      repeat (hp) @(posedge clk);
      sclk <= 1'b0;
      if (i < nb - 1) mosi <= din[nb-2-i];
      repeat (hp) @(posedge clk);
    end
    cs_n <= 1'b1;
    busy = 1'b0;
  endtask
  // Select held with a still clock, as a hung host would leave it
  task automatic stall(input int n);
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (n) @(posedge clk);
    cs_n <= 1'b1;
  endtask
endmodule // srci_host_model

// ==== srci_in_filter.sv ====
// Input filter for one serial pin; the caller finds the edges.
// Assumes the pin is already synchronised to clk.
module srci_in_filter
  import srci_pkg::*;
#(
  parameter int unsigned DELAY = INPUT_FILTER_EN_CYC,
  parameter logic INIT = 1'b1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic input_filter_en_en,
  input wire logic pin_sync,
  output logic level
);
  logic [$clog2(DELAY+1)-1:0] cnt_reg;
  logic stable_reg;

  // When enabled, output follows the pin only after it held still for DELAY cycles; disabled, it follows one cycle later
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_reg <= '0;
      stable_reg <= INIT;
    end else if (!input_filter_en_en || pin_sync == stable_reg) begin
      cnt_reg <= '0;
      stable_reg <= input_filter_en_en ? stable_reg : pin_sync;
    end else if (cnt_reg == ($clog2(DELAY+1))'(DELAY - 1)) begin
      cnt_reg <= '0;
      stable_reg <= pin_sync;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
  assign level = stable_reg;
endmodule // srci_in_filter

// ==== srci_pkg.sv ====
// Shared constants for the serial responder with checksum.
// Assumes a 250 MHz core clock; all times convert to cycles here.
package srci_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned CLK_PERIOD_NS = 4;
  // Input filter delay
  localparam int unsigned INPUT_FILTER_EN_NS = 200;
  localparam int unsigned INPUT_FILTER_EN_CYC = (INPUT_FILTER_EN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Oscillator start-up time
  localparam int unsigned OSC_START_US = 50;
  localparam int unsigned OSC_START_CYC = OSC_START_US * CLK_MHZ;
  // Frozen bus timeout in seconds
  localparam int unsigned FROZEN_S = 2;
  localparam longint unsigned FROZEN_CYC = 64'(FROZEN_S) * 64'd250000000;
  // Fast oscillator idle hold, one second base
  localparam longint unsigned SEC_CYC = 64'd250000000;
  localparam int unsigned MIN_IDLE_S = 1;
  // Internal processing time for direct commands
  localparam int unsigned PROC_US = 50;
  localparam int unsigned PROC_CYC = PROC_US * CLK_MHZ;
  // Frame lengths
  localparam logic [4:0] BITS_PLAIN = 5'd16;
  localparam logic [4:0] BITS_CRC = 5'd24;
  // Sentinel values and checksum constants
  localparam logic [15:0] FLAG_WORD = 16'hffff;
  localparam logic [7:0] CRC_ERR_FLAG = 8'haa;
  localparam logic [7:0] OSC_OFF_FLAG = 8'hff;
  localparam logic [7:0] STALE_FLAG = 8'h00;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  // Drive rail reset choice: 0 low rail, 1 aux rail
  localparam logic RAIL_RST = 1'b0;
  // Serial clock idle level in mode 0, used as its filter and edge reset value
  localparam logic SCLK_IDLE = 1'b0;
endpackage

// ==== srci_responder.sv ====
// Serial responder, mode 0, 16 or 24 bit frames with checksum.
// Assumes sclk, mosi and cs_n are host pins; internal logic uses the core port.
module srci_responder
  import srci_pkg::*;
#(
  parameter int unsigned OSC_CYC = OSC_START_CYC,
  parameter longint unsigned SEC_CYCLES = SEC_CYC,
  parameter longint unsigned FROZEN_CYCLES = FROZEN_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe_n,
  input wire logic crc_en,
  input wire logic input_filter_en,
  input wire logic out_drive_rail_cfg,
  input wire logic switch_to_serial_cmd,
  input wire logic [7:0] idle_time_s,
  output logic out_drive_rail_sel,
  output logic fast_oscillator_on,
  output logic rx_valid,
  output logic rx_write,
  output logic [6:0] rx_addr,
  output logic [7:0] rx_data,
  input wire logic tx_load,
  input wire logic [15:0] tx_word,
  output logic frame_error,
  output logic bus_frozen
);
  // Two-flop synchronisers for the three host pins
  logic [2:0] sync1_reg, sync2_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_reg <= 3'h4; // Select high, clock low: mode 0 idle, no false edge
      sync2_reg <= 3'h4;
    end else begin
      sync1_reg <= {cs_n, mosi, sclk};
      sync2_reg <= sync1_reg;
    end
  end

  logic sclk_f, mosi_f, cs_f;
  srci_in_filter #(.INIT(SCLK_IDLE)) u_f_sclk (.clk(clk), .reset(reset), .input_filter_en_en(input_filter_en),
    .pin_sync(sync2_reg[0]), .level(sclk_f));
  srci_in_filter u_f_mosi (.clk(clk), .reset(reset), .input_filter_en_en(input_filter_en),
    .pin_sync(sync2_reg[1]), .level(mosi_f));
  srci_in_filter u_f_cs (.clk(clk), .reset(reset), .input_filter_en_en(input_filter_en),
    .pin_sync(sync2_reg[2]), .level(cs_f));

  // Edge detection on filtered levels
  logic sclk_d_reg, cs_d_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      sclk_d_reg <= SCLK_IDLE;
      cs_d_reg <= 1'b1;
    end else begin
      sclk_d_reg <= sclk_f;
      cs_d_reg <= cs_f;
    end
  end
  wire sclk_rise = sclk_f & ~sclk_d_reg;
  wire sclk_fall = ~sclk_f & sclk_d_reg;
  wire cs_fall = ~cs_f & cs_d_reg;
  wire cs_rise = cs_f & ~cs_d_reg;
  wire active = ~cs_f;

  // Fast oscillator: started by chip-select fall, ready after start-up time
  typedef enum logic [1:0] {
    SRCI_OSC_OFF = 2'b00,
    SRCI_OSC_START = 2'b01,
    SRCI_OSC_RUN = 2'b10
  } srci_osc_t;
  srci_osc_t osc_reg;
  logic [31:0] osc_cnt_reg;
  logic [63:0] idle_cnt_reg;
  logic [7:0] idle_sec_reg;
  wire [7:0] hold_s = (idle_time_s < 8'(MIN_IDLE_S)) ? 8'(MIN_IDLE_S) : idle_time_s;
  always_ff @(posedge clk) begin
    if (reset) begin
      osc_reg <= SRCI_OSC_OFF;
      osc_cnt_reg <= 32'h0;
      idle_cnt_reg <= 64'h0;
      idle_sec_reg <= 8'h0;
    end else begin
      case (osc_reg)
        SRCI_OSC_OFF: begin
          if (cs_fall) begin
            osc_reg <= SRCI_OSC_START;
            osc_cnt_reg <= 32'h0;
          end
        end
        SRCI_OSC_START: begin
          if (osc_cnt_reg == 32'(OSC_CYC - 1)) begin
            osc_reg <= SRCI_OSC_RUN;
            idle_cnt_reg <= 64'h0;
            idle_sec_reg <= 8'h0;
          end else begin
            osc_cnt_reg <= osc_cnt_reg + 32'h1;
          end
        end
        SRCI_OSC_RUN: begin
          // Any frame restarts the idle window
          if (active) begin
            idle_cnt_reg <= 64'h0;
            idle_sec_reg <= 8'h0;
          end else if (idle_cnt_reg == SEC_CYCLES - 64'h1) begin
            idle_cnt_reg <= 64'h0;
            if (idle_sec_reg + 8'h1 >= hold_s) begin
              osc_reg <= SRCI_OSC_OFF;
            end else begin
              idle_sec_reg <= idle_sec_reg + 8'h1;
            end
          end else begin
            idle_cnt_reg <= idle_cnt_reg + 64'h1;
          end
        end
        default: osc_reg <= SRCI_OSC_OFF;
      endcase
    end
  end
  wire osc_ready = (osc_reg == SRCI_OSC_RUN);

  // Frozen bus watchdog: cs low, clock static
  logic [63:0] frz_cnt_reg;
  logic frozen_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      frz_cnt_reg <= 64'h0;
      frozen_reg <= 1'b0;
    end else if (!active || sclk_rise || sclk_fall) begin
      frz_cnt_reg <= 64'h0;
      frozen_reg <= 1'b0;
    end else if (frz_cnt_reg == FROZEN_CYCLES - 64'h1) begin
      frz_cnt_reg <= 64'h0;
      frozen_reg <= 1'b1;
    end else begin
      frz_cnt_reg <= frz_cnt_reg + 64'h1;
      frozen_reg <= 1'b0;
    end
  end
  wire frame_kill = frozen_reg;

  // Frame shift logic; frame mode latched at chip-select fall
  logic [4:0] bit_cnt_reg;
  logic [23:0] rx_sh_reg;
  logic [23:0] tx_sh_reg;
  logic [7:0] crc_rx_reg;
  logic mode_crc_reg;
  logic osc_at_start_reg;
  logic [7:0] crc_rx_next;
  srci_crc8 u_crc_rx (.crc_in(crc_rx_reg), .bit_in(mosi_f), .crc_out(crc_rx_next));

  // Outgoing buffer state
  logic [15:0] obuf_reg;
  logic [7:0] ocrc_reg;
  logic ofresh_reg;
  logic oerr_reg;

  // Checksum of the outgoing buffer, bit-serial over 16 steps
  logic [7:0] tx_crc;
  always_comb begin
    tx_crc = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      tx_crc = {tx_crc[6:0], 1'b0} ^ ((tx_crc[7] ^ obuf_reg[i]) ? CRC_POLY : 8'h00);
    end
  end

  // Word shifted out this frame, fixed at chip-select fall
  logic [23:0] tx_load_word;
  always_comb begin
    if (!osc_ready) begin
      tx_load_word = {FLAG_WORD, OSC_OFF_FLAG};
    end else if (oerr_reg) begin
      tx_load_word = {obuf_reg, ocrc_reg};
    end else if (!ofresh_reg) begin
      tx_load_word = {FLAG_WORD, STALE_FLAG};
    end else begin
      tx_load_word = {obuf_reg, tx_crc};
    end
  end

  always_ff @(posedge clk) begin
    if (reset || frame_kill) begin
      bit_cnt_reg <= 5'h0;
      rx_sh_reg <= 24'h0;
      tx_sh_reg <= 24'hffffff;
      crc_rx_reg <= CRC_INIT;
      mode_crc_reg <= 1'b0;
      osc_at_start_reg <= 1'b0;
    end else if (cs_fall) begin
      bit_cnt_reg <= 5'h0;
      crc_rx_reg <= CRC_INIT;
      mode_crc_reg <= crc_en;
      osc_at_start_reg <= osc_ready;
      tx_sh_reg <= tx_load_word;
    end else if (active && sclk_rise) begin
      // Sample on rising edge, MSB first
      rx_sh_reg <= {rx_sh_reg[22:0], mosi_f};
      if (bit_cnt_reg < 5'd16) begin
        crc_rx_reg <= crc_rx_next;
      end
      if (bit_cnt_reg != 5'h1f) begin
        bit_cnt_reg <= bit_cnt_reg + 5'h1;
      end
    end else if (active && sclk_fall) begin
      tx_sh_reg <= {tx_sh_reg[22:0], 1'b1};
    end
  end

  // End of frame evaluation at chip-select rise
  wire [4:0] want_bits = mode_crc_reg ? BITS_CRC : BITS_PLAIN;
  wire len_ok = (bit_cnt_reg == want_bits);
  wire crc_ok = !mode_crc_reg || (rx_sh_reg[7:0] == crc_rx_reg);
  wire [15:0] frame_word = mode_crc_reg ? rx_sh_reg[23:8] : rx_sh_reg[15:0];
  wire frame_end = cs_rise && !frame_kill;
  wire frame_good = frame_end && len_ok && crc_ok && osc_at_start_reg;
  wire crc_bad = frame_end && mode_crc_reg && !(len_ok && crc_ok);

  // Incoming buffer handed to internal logic
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_valid <= 1'b0;
      rx_write <= 1'b0;
      rx_addr <= 7'h0;
      rx_data <= 8'h0;
      frame_error <= 1'b0;
    end else begin
      rx_valid <= frame_good;
      frame_error <= frame_end && !(len_ok && crc_ok);
      if (frame_good) begin
        rx_write <= frame_word[15];
        rx_addr <= frame_word[14:8];
        rx_data <= frame_word[7:0];
      end
    end
  end

  // Outgoing buffer: refresh wins over the stale mark in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      obuf_reg <= FLAG_WORD;
      ocrc_reg <= STALE_FLAG;
      ofresh_reg <= 1'b0;
      oerr_reg <= 1'b0;
    end else if (tx_load) begin
      obuf_reg <= tx_word;
      ofresh_reg <= 1'b1;
      oerr_reg <= 1'b0;
    end else if (crc_bad) begin
      obuf_reg <= FLAG_WORD;
      ocrc_reg <= CRC_ERR_FLAG;
      oerr_reg <= 1'b1;
      ofresh_reg <= 1'b0;
    end else if (frame_end) begin
      ofresh_reg <= 1'b0;
      oerr_reg <= 1'b0;
    end
  end

  // Output pin: driven while selected, released otherwise
  always_ff @(posedge clk) begin
    if (reset) begin
      miso <= 1'b1;
      miso_oe_n <= 1'b1;
    end else begin
      // Idle high while deselected, so a short frame never leaves a stray bit
      miso <= active ? tx_sh_reg[23] : 1'b1;
      miso_oe_n <= ~active;
    end
  end

  // Drive rail and oscillator status; rail only moves on switch command
  always_ff @(posedge clk) begin
    if (reset) begin
      out_drive_rail_sel <= RAIL_RST;
      fast_oscillator_on <= 1'b0;
      bus_frozen <= 1'b0;
    end else begin
      if (switch_to_serial_cmd) begin
        out_drive_rail_sel <= out_drive_rail_cfg;
      end
      fast_oscillator_on <= (osc_reg != SRCI_OSC_OFF);
      bus_frozen <= frozen_reg;
    end
  end

  sequence s_bad_frame;
    crc_bad && !tx_load;
  endsequence
  a_crc_err_load: assert property (@(posedge clk) disable iff (reset)
    s_bad_frame |=> (obuf_reg == FLAG_WORD) && (ocrc_reg == CRC_ERR_FLAG))
    else $error("checksum failure did not load sentinel");
  a_stale_mark: assert property (@(posedge clk) disable iff (reset)
    frame_end && !tx_load |=> !ofresh_reg)
    else $error("buffer not stale after frame");
  a_osc_off_word: assert property (@(posedge clk) disable iff (reset)
    cs_fall && !osc_ready && !frame_kill |=> tx_sh_reg == 24'hffffff)
    else $error("oscillator off word wrong");
  a_stale_word: assert property (@(posedge clk) disable iff (reset)
    cs_fall && osc_ready && !oerr_reg && !ofresh_reg && !frame_kill
    |=> tx_sh_reg == 24'hffff00)
    else $error("stale word wrong");
  a_len_error: assert property (@(posedge clk) disable iff (reset)
    frame_end && !mode_crc_reg && bit_cnt_reg != 5'd16 |=> frame_error)
    else $error("wrong length not flagged");
  a_bad_reject: assert property (@(posedge clk) disable iff (reset)
    frame_end && !crc_ok |=> !rx_valid)
    else $error("bad checksum accepted");
  a_osc_wake: assert property (@(posedge clk) disable iff (reset)
    cs_fall && osc_reg == SRCI_OSC_OFF |=> osc_reg == SRCI_OSC_START ##1 !osc_ready)
    else $error("oscillator not started");
  a_rail_hold: assert property (@(posedge clk) disable iff (reset)
    !switch_to_serial_cmd |=> $stable(out_drive_rail_sel))
    else $error("rail changed without switch");
  a_write_fields: assert property (@(posedge clk) disable iff (reset)
    frame_good |=> rx_valid && rx_write == $past(frame_word[15]))
    else $error("direction bit wrong");
endmodule // srci_responder

// ==== tb_top.sv ====
// Self-checking bench for the serial responder with checksum.
// Assumes the host model drives the pins; a small model stands for internal logic.
module tb_top;
  import srci_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int GAP = 300; // Shortened frame spacing keeps the run short
  logic clk = 1'b0, reset = 1'b1, sclk, cs_n, mosi, miso, miso_oe_n;
  logic crc_en = 1'b0, input_filter_en = 1'b0, out_drive_rail_cfg = 1'b0;
  logic switch_to_serial_cmd = 1'b0, tx_load = 1'b0, out_drive_rail_sel;
  logic [7:0] idle_time_s = 8'h05, rx_data;
  logic [6:0] rx_addr;
  logic [15:0] tx_word = 16'h0000;
  logic fast_oscillator_on, rx_valid, rx_write, frame_error, bus_frozen;
  int err_count = 0, n_tests = 0, n_rx = 0, n_fe = 0, n_fz = 0, dly = 0, hp = 6;
  bit auto_resp = 1'b1;
  always #2 clk = ~clk;
  srci_responder #(.OSC_CYC(20), .SEC_CYCLES(200), .FROZEN_CYCLES(300)) u_srci_responder (
    .clk, .reset, .sclk, .cs_n, .mosi, .miso, .miso_oe_n, .crc_en, .input_filter_en,
    .out_drive_rail_cfg, .switch_to_serial_cmd, .idle_time_s, .out_drive_rail_sel,
    .fast_oscillator_on, .rx_valid, .rx_write, .rx_addr, .rx_data, .tx_load, .tx_word,
    .frame_error, .bus_frozen);
  srci_host_model u_srci_host_model (.clk, .sclk, .cs_n, .mosi, .miso);
  // Read data of the internal model, a plain function of the address
  function automatic logic [7:0] rd(logic [6:0] a);
    return {1'b0, a} ^ 8'h5a;
  endfunction
  function automatic logic [7:0] crc8(logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  function automatic logic [23:0] rep(logic [15:0] w);
    return crc_en ? {w, crc8(w)} : {8'h00, w};
  endfunction
  // Internal logic answers a good frame ten cycles later; also counts pulses
  always @(posedge clk) begin
    tx_load <= (dly == 1);
    if (rx_valid) n_rx <= n_rx + 1;
    if (frame_error) n_fe <= n_fe + 1;
    if (bus_frozen) n_fz <= n_fz + 1;
    if (rx_valid && auto_resp) dly <= 10;
    else if (dly > 0) dly <= dly - 1;
    if (dly == 1) begin
      tx_word <= {rx_write, rx_addr, rx_write ? rx_data : rd(rx_addr)};
    end
  end
  task automatic check(input string nm, input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Kind: 0 refused, 1 good, 2 oscillator off, 3 good with reply unchecked
  task automatic xf(input int nb, input logic [23:0] din, input logic [23:0] exp,
                    input int kind);
    int r0;
    int e0;
    logic [23:0] got;
    r0 = n_rx;
    e0 = n_fe;
    u_srci_host_model.frame(nb, hp, din, got);
    repeat (hp + 4) @(posedge clk);
    if (kind == 1 || kind == 2) check("reply", got, exp);
    check("rx count", 24'(n_rx - r0), 24'(kind % 2));
    if (kind != 2) check("error count", 24'(n_fe - e0), 24'(kind == 0));
    if (kind % 2 == 1) check("rx head", 24'({rx_write, rx_addr, rx_data}), 24'(din >> (nb - 16)));
    check("idle pins", 24'({miso_oe_n, miso}), 24'h3);
    repeat (GAP) @(posedge clk);
  endtask
  task automatic test_done;
    $display("Checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Watchdog, well beyond the roughly 15000 cycles the tests need
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    test_done;
  end
  initial begin
    int n0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check("reset pins", 24'({miso_oe_n, miso, fast_oscillator_on, out_drive_rail_sel}), 24'hc);
    xf(16, 24'h9234, 24'h00ffff, 2);
    check("osc on", 24'(fast_oscillator_on), 24'h1);
    xf(16, 24'h9234, 24'h00ffff, 1);
    xf(16, 24'h0533, 24'h009234, 1);
    xf(15, 24'h1234, 24'h0, 0);
    xf(17, 24'h1234, 24'h0, 0);
    xf(16, 24'h1100, 24'h0, 3);
    crc_en <= 1'b1;
    @(posedge clk);
    xf(24, {16'h9e5a, crc8(16'h9e5a)}, rep({8'h11, rd(7'h11)}), 1);
    xf(24, {16'h2a00, crc8(16'h2a00)}, rep(16'h9e5a), 1);
    xf(24, {16'h8111, ~crc8(16'h8111)}, 24'h0, 0);
    xf(24, {16'h8111, crc8(16'h8111)}, 24'hffffaa, 1);
    xf(16, 24'h3000, 24'h0, 0);
    xf(24, {16'h3100, crc8(16'h3100)}, 24'hffffaa, 1);
    auto_resp = 1'b0;
    xf(24, {16'h3200, crc8(16'h3200)}, rep({8'h31, rd(7'h31)}), 1);
    auto_resp = 1'b1;
    xf(24, {16'h4000, crc8(16'h4000)}, 24'hffff00, 1);
    input_filter_en <= 1'b1;
    hp = 70;
    @(posedge clk);
    xf(24, {16'hb344, crc8(16'hb344)}, rep({8'h40, rd(7'h40)}), 1);
    input_filter_en <= 1'b0;
    hp = 6;
    out_drive_rail_cfg <= 1'b1;
    repeat (20) @(posedge clk);
    check("rail held", 24'(out_drive_rail_sel), 24'h0);
    switch_to_serial_cmd <= 1'b1;
    @(posedge clk);
    switch_to_serial_cmd <= 1'b0;
    repeat (5) @(posedge clk);
    check("rail applied", 24'(out_drive_rail_sel), 24'h1);
    // A still clock under a held select must reset the interface once
    n0 = n_fz;
    u_srci_host_model.stall(400);
    repeat (10) @(posedge clk);
    check("frozen", 24'(n_fz - n0), 24'h1);
    xf(24, {16'h3400, crc8(16'h3400)}, 24'h0, 3);
    // Zero idle time still holds the oscillator for one scaled second
    idle_time_s <= 8'h00;
    repeat (1500) @(posedge clk);
    check("osc off", 24'(fast_oscillator_on), 24'h0);
    u_srci_host_model.stall(12);
    check("osc woken", 24'(fast_oscillator_on), 24'h1);
    repeat (140) @(posedge clk);
    check("osc held", 24'(fast_oscillator_on), 24'h1);
    repeat (400) @(posedge clk);
    check("osc idle", 24'(fast_oscillator_on), 24'h0);
    xf(24, {16'h3500, crc8(16'h3500)}, 24'hffffff, 2);
    test_done;
  end
endmodule // tb_top
